// ==== rtl/amc_pkg.sv ====
/*
 * Shared constants for the converter mode, format and sync control block.
 * Assumes a single master clock drives all conversion timing.
 */
package amc_pkg;

    // Two-bit operating mode codes held internally.
    localparam logic [1:0] MODE_HIGH_SPEED = 2'h0;
    localparam logic [1:0] MODE_HIGH_RES = 2'h1;
    localparam logic [1:0] MODE_LOW_POWER = 2'h2;

    // Conversion lengths in master clock periods.
    localparam int CONV_SHORT_CYCLES = 256;
    localparam int CONV_LONG_CYCLES = 512;
    localparam int CONV_CNT_W = 10;

    // Frame periods above this count are taken as the 512 ratio.
    localparam int FRAME_RATIO_SPLIT = 384;
    localparam logic [CONV_CNT_W-1:0] FRAME_CNT_MAX = 10'h3ff;

    // Filter settling length, in conversions, per mode.
    localparam int SETTLE_CONV_FAST = 76;
    localparam int SETTLE_CONV_HIGH_RES = 78;
    localparam int SETTLE_CNT_W = 7;

    // Length of the offset self-calibration, in conversions.
    localparam int CAL_CONVERSIONS = 16;

    // Default mode debounce and power-down hold, in master clock periods.
    localparam int MODE_DEBOUNCE_DEFAULT = 12288;
    localparam int DEBOUNCE_CNT_W = 14;
    localparam int POWERDOWN_HOLD_DEFAULT = 524288;
    localparam int POWERDOWN_CNT_W = 20;

    // Reset values of the control outputs.
    localparam logic [1:0] ACTIVE_MODE_RESET = MODE_HIGH_SPEED;
    localparam logic DATA_READY_N_RESET = 1'b1;

    // Control states.
    typedef enum logic [2:0] {
        CtlSettle,
        CtlReady,
        CtlSyncHold,
        CtlPowerDown,
        CtlSelfCal
    } amc_state_t;

endpackage

// ==== rtl/amc_control.sv ====
/*
 * Pin-driven mode, format and sync/power-down control of a converter.
 * Assumes all pins are asynchronous to mclk and that the serial shifter
 * supplies serialBitIn on the sclk domain.
 */
// Function
// - High-Speed conversions last 256 master clock periods.
// - High-Res and Low-Power with SPI format convert in 512 periods.
// - Frame format detects 256 or 512 ratio; High-Speed always 256.
// - Mode pin: low High-Speed, floating High-Res, high Low-Power.
// - A new mode state acts only after 12288 stable periods.
// - Any mode change discards the stored offset calibration.
// - SPI format: data-ready stays high after mode change until settled.
// - Frame format: data output low after mode change until settled.
// - Format pin low selects SPI, high selects frame sync.
// - Sync low halts conversions and resets filter counters.
// - Sync held low beyond 2^19 periods enters power-down.
// - SPI: data-ready high on sync, through settling, then low.
// - Frame: data output low on sync and through settling.
// - Sync request is found by the sync pin falling edge.
// - Leaving power-down runs offset self-calibration, inputs shorted.
// - After power-down exit, ready or data output held until settled.
`timescale 1ns/1ps

module amc_control #(
    parameter int MODE_DEBOUNCE_CYCLES = amc_pkg::MODE_DEBOUNCE_DEFAULT,
    parameter int POWERDOWN_HOLD_CYCLES = amc_pkg::POWERDOWN_HOLD_DEFAULT
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic modeDriven,
    input wire logic modeLevel,
    input wire logic formatSel,
    input wire logic sync_powerdown_n,
    input wire logic frame_sync_in,
    input wire logic sclk,
    input wire logic serialBitIn,
    output logic [1:0] activeMode,
    output logic frameFormat,
    output logic frameRatio512,
    output logic convStart,
    output logic filterReset,
    output logic offsetCalClear,
    output logic offsetCalValid,
    output logic powerDown,
    output logic inputsShorted,
    output logic data_ready_n,
    output logic serialDataOut
);

    localparam logic [amc_pkg::DEBOUNCE_CNT_W-1:0] DEBOUNCE_LAST =
        amc_pkg::DEBOUNCE_CNT_W'(MODE_DEBOUNCE_CYCLES - 1);
    localparam logic [amc_pkg::POWERDOWN_CNT_W-1:0] PD_LIMIT =
        amc_pkg::POWERDOWN_CNT_W'(POWERDOWN_HOLD_CYCLES);

    // Pin bits: 0 mode driven, 1 mode level, 2 format, 3 sync, 4 frame.
    logic [4:0] pinMeta_q;
    logic [4:0] pinSync_q;
    logic syncPrev_q, fsPrev_q, initDone_q, initDone_d;
    logic [1:0] activeMode_q, activeMode_d, candMode_q, candMode_d;
    logic [amc_pkg::DEBOUNCE_CNT_W-1:0] dbCnt_q, dbCnt_d;
    logic [amc_pkg::CONV_CNT_W-1:0] frameCnt_q, frameCnt_d;
    logic [amc_pkg::CONV_CNT_W-1:0] convCnt_q, convCnt_d, convLast;
    logic [amc_pkg::POWERDOWN_CNT_W-1:0] pdCnt_q, pdCnt_d;
    logic [amc_pkg::SETTLE_CNT_W-1:0] settleCnt_q, settleCnt_d, settleLast;
    logic ratio512_q, ratio512_d, calValid_q, calValid_d;
    logic dataReadyN_q, dataReadyN_d, readyLvl_q, readyLvl_d;
    logic convStart_d, convStart_q, calClear_d, calClear_q;
    amc_pkg::amc_state_t state_q, state_d;
    logic [1:0] rawMode;
    logic syncLvl, fsLvl, fmtLvl, syncFall, fsRise, convDone, modeApply;
    logic running;
    logic [1:0] warm_q;

    // Three-level pin decode into the internal two-bit mode code.
    function automatic logic [1:0] decodeMode(input logic driven,
                                              input logic level);
        if (!driven)
            return amc_pkg::MODE_HIGH_RES;
        return level ? amc_pkg::MODE_LOW_POWER
                     : amc_pkg::MODE_HIGH_SPEED;
    endfunction

    // Two-stage synchronisers for every pin input. The sync bit rests high
    // so that leaving reset shows no false falling edge, and the warm-up
    // shift marks when real pin levels have reached the second stage.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pinMeta_q <= 5'h08;
            pinSync_q <= 5'h08;
            warm_q <= 2'h0;
        end
        else
        begin
            warm_q <= {warm_q[0], 1'b1};
            pinMeta_q <= {frame_sync_in, sync_powerdown_n, formatSel,
                          modeLevel, modeDriven};
            pinSync_q <= pinMeta_q;
        end
    end

    assign rawMode = decodeMode(pinSync_q[0], pinSync_q[1]);
    assign fmtLvl = pinSync_q[2];
    assign syncLvl = pinSync_q[3];
    assign fsLvl = pinSync_q[4];
    assign syncFall = syncPrev_q & ~syncLvl;
    assign fsRise = fsLvl & ~fsPrev_q;
    assign running = (state_q == amc_pkg::CtlSettle) ||
                     (state_q == amc_pkg::CtlReady) ||
                     (state_q == amc_pkg::CtlSelfCal);

    // Conversion length picked from mode, format and measured frame.
    always_comb
    begin
        if (activeMode_q == amc_pkg::MODE_HIGH_SPEED)
            convLast = amc_pkg::CONV_CNT_W'(amc_pkg::CONV_SHORT_CYCLES - 1);
        else if (!fmtLvl)
            convLast = amc_pkg::CONV_CNT_W'(amc_pkg::CONV_LONG_CYCLES - 1);
        else if (ratio512_q)
            convLast = amc_pkg::CONV_CNT_W'(amc_pkg::CONV_LONG_CYCLES - 1);
        else
            convLast = amc_pkg::CONV_CNT_W'(amc_pkg::CONV_SHORT_CYCLES - 1);
        settleLast = (activeMode_q == amc_pkg::MODE_HIGH_RES) ?
            amc_pkg::SETTLE_CNT_W'(amc_pkg::SETTLE_CONV_HIGH_RES - 1) :
            amc_pkg::SETTLE_CNT_W'(amc_pkg::SETTLE_CONV_FAST - 1);
    end

    // A shortened length, after a format or ratio change, ends at once.
    assign convDone = running && (convCnt_q >= convLast);

    // Next values of the frame meter, mode debounce and control sequence.
    always_comb
    begin
        frameCnt_d = frameCnt_q;
        ratio512_d = ratio512_q;
        initDone_d = warm_q[1];
        activeMode_d = activeMode_q;
        candMode_d = candMode_q;
        dbCnt_d = dbCnt_q;
        modeApply = 1'b0;
        state_d = state_q;
        convCnt_d = convCnt_q;
        pdCnt_d = pdCnt_q;
        settleCnt_d = settleCnt_q;
        calValid_d = calValid_q;
        convStart_d = 1'b0;
        calClear_d = 1'b0;
        // Frame period meter in master clock periods.
        if (fsRise)
        begin
            ratio512_d = frameCnt_q >
                amc_pkg::CONV_CNT_W'(amc_pkg::FRAME_RATIO_SPLIT);
            frameCnt_d = '0;
        end
        else if (frameCnt_q != amc_pkg::FRAME_CNT_MAX)
            frameCnt_d = frameCnt_q + 1'b1;
        // Mode debounce: the first decode is taken at once after reset.
        if (!initDone_q)
        begin
            if (warm_q[1])
            begin
                activeMode_d = rawMode;
                candMode_d = rawMode;
            end
        end
        else if (rawMode != candMode_q)
        begin
            candMode_d = rawMode;
            dbCnt_d = '0;
        end
        else if (candMode_q != activeMode_q)
        begin
            if (dbCnt_q == DEBOUNCE_LAST)
            begin
                activeMode_d = candMode_q;
                modeApply = 1'b1;
                dbCnt_d = '0;
            end
            else
                dbCnt_d = dbCnt_q + 1'b1;
        end
        else
            dbCnt_d = '0;
        // Conversion counter runs only while converting.
        if (running)
            convCnt_d = convDone ? '0 : convCnt_q + 1'b1;
        else
            convCnt_d = '0;
        convStart_d = convDone;
        unique case (state_q)
            amc_pkg::CtlSettle:
                if (convDone)
                begin
                    settleCnt_d = settleCnt_q + 1'b1;
                    if (settleCnt_q >= settleLast)
                        state_d = amc_pkg::CtlReady;
                end
            amc_pkg::CtlReady: ;
            amc_pkg::CtlSyncHold:
                if (syncLvl)
                    state_d = amc_pkg::CtlSettle;
                else if (pdCnt_q == PD_LIMIT)
                    state_d = amc_pkg::CtlPowerDown;
                else
                    pdCnt_d = pdCnt_q + 1'b1;
            amc_pkg::CtlPowerDown:
                if (syncLvl)
                begin
                    state_d = amc_pkg::CtlSelfCal;
                    settleCnt_d = '0;
                end
            amc_pkg::CtlSelfCal:
                if (convDone)
                begin
                    settleCnt_d = settleCnt_q + 1'b1;
                    if (settleCnt_q == amc_pkg::SETTLE_CNT_W'(
                            amc_pkg::CAL_CONVERSIONS - 1))
                    begin
                        calValid_d = 1'b1;
                        settleCnt_d = '0;
                        state_d = amc_pkg::CtlSettle;
                    end
                end
        endcase
        // A sync request overrides everything that is converting.
        if (running && syncFall)
        begin
            state_d = amc_pkg::CtlSyncHold;
            convCnt_d = '0;
            convStart_d = 1'b0;
            pdCnt_d = '0;
            settleCnt_d = '0;
        end
        // A mode change drops the offset and restarts settling.
        if (modeApply)
        begin
            calValid_d = 1'b0;
            calClear_d = 1'b1;
            convCnt_d = '0;
            convStart_d = 1'b0;
            if (state_d == amc_pkg::CtlSettle ||
                state_d == amc_pkg::CtlReady)
            begin
                state_d = amc_pkg::CtlSettle;
                settleCnt_d = '0;
            end
        end
        readyLvl_d = (state_d == amc_pkg::CtlReady);
        dataReadyN_d = !(readyLvl_d && !fmtLvl);
    end

    // Registers of the master clock domain.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            syncPrev_q <= 1'b1;
            fsPrev_q <= 1'b0;
            initDone_q <= 1'b0;
            activeMode_q <= amc_pkg::ACTIVE_MODE_RESET;
            candMode_q <= amc_pkg::ACTIVE_MODE_RESET;
            dbCnt_q <= '0;
            frameCnt_q <= '0;
            ratio512_q <= 1'b1;
            state_q <= amc_pkg::CtlSettle;
            convCnt_q <= '0;
            pdCnt_q <= '0;
            settleCnt_q <= '0;
            calValid_q <= 1'b0;
            convStart_q <= 1'b0;
            calClear_q <= 1'b0;
            readyLvl_q <= 1'b0;
            dataReadyN_q <= amc_pkg::DATA_READY_N_RESET;
        end
        else
        begin
            syncPrev_q <= syncLvl;
            fsPrev_q <= fsLvl;
            initDone_q <= initDone_d;
            activeMode_q <= activeMode_d;
            candMode_q <= candMode_d;
            dbCnt_q <= dbCnt_d;
            frameCnt_q <= frameCnt_d;
            ratio512_q <= ratio512_d;
            state_q <= state_d;
            convCnt_q <= convCnt_d;
            pdCnt_q <= pdCnt_d;
            settleCnt_q <= settleCnt_d;
            calValid_q <= calValid_d;
            convStart_q <= convStart_d;
            calClear_q <= calClear_d;
            readyLvl_q <= readyLvl_d;
            dataReadyN_q <= dataReadyN_d;
        end
    end

    // Serial output side on the shift clock; settled level crosses in.
    logic readyMeta_q, readySclk_q, fmtMeta_q, fmtSclk_q, serialOut_q;
    always_ff @(posedge sclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            readyMeta_q <= 1'b0;
            readySclk_q <= 1'b0;
            fmtMeta_q <= 1'b0;
            fmtSclk_q <= 1'b0;
            serialOut_q <= 1'b0;
        end
        else
        begin
            readyMeta_q <= readyLvl_q;
            readySclk_q <= readyMeta_q;
            fmtMeta_q <= formatSel;
            fmtSclk_q <= fmtMeta_q;
            serialOut_q <= serialBitIn & (readySclk_q | ~fmtSclk_q);
        end
    end

    assign activeMode = activeMode_q;
    assign frameFormat = fmtLvl;
    assign frameRatio512 = ratio512_q;
    assign convStart = convStart_q;
    assign filterReset = !running;
    assign offsetCalClear = calClear_q;
    assign offsetCalValid = calValid_q;
    assign powerDown = (state_q == amc_pkg::CtlPowerDown);
    assign inputsShorted = (state_q == amc_pkg::CtlSelfCal);
    assign data_ready_n = dataReadyN_q;
    assign serialDataOut = serialOut_q;

    // Gap between conversion starts, valid while steadily converting.
    logic [amc_pkg::CONV_CNT_W-1:0] gapCnt_q;
    logic gapValid_q;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gapCnt_q <= '0;
            gapValid_q <= 1'b0;
        end
        else
        begin
            gapCnt_q <= convStart_d ? '0 : gapCnt_q + 1'b1;
            gapValid_q <= convStart_d ? (running && !modeApply && !fsRise)
                          : (gapValid_q && running && !modeApply);
        end
    end

    hs_period_a: assert property (@(posedge mclk) disable iff (!reset_n)
        convStart_d && gapValid_q && activeMode_q == amc_pkg::MODE_HIGH_SPEED
        |-> gapCnt_q == 10'h0ff)
        else $error("High-Speed conversion period is not 256 cycles.");
    spi_period_a: assert property (@(posedge mclk) disable iff (!reset_n)
        convStart_d && gapValid_q && !fmtLvl && $stable(fmtLvl) &&
        activeMode_q != amc_pkg::MODE_HIGH_SPEED |-> gapCnt_q == 10'h1ff)
        else $error("SPI long conversion period is not 512 cycles.");
    frame_ratio_a: assert property (@(posedge mclk) disable iff (!reset_n)
        fsRise && initDone_q |=> ratio512_q == ($past(frameCnt_q) > 10'h180))
        else $error("Frame ratio detection picked the wrong length.");
    mode_decode_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(initDone_q) |-> activeMode_q == $past(rawMode))
        else $error("Start-up mode does not match the mode pin.");
    mode_debounce_a: assert property (@(posedge mclk) disable iff (!reset_n)
        initDone_q && $past(initDone_q) && $changed(activeMode_q)
        |-> $past(dbCnt_q) == DEBOUNCE_LAST)
        else $error("Mode changed before the debounce count completed.");
    cal_discard_a: assert property (@(posedge mclk) disable iff (!reset_n)
        modeApply |=> offsetCalClear && !offsetCalValid)
        else $error("Offset calibration kept across a mode change.");
    mode_settle_a: assert property (@(posedge mclk) disable iff (!reset_n)
        modeApply && !fmtLvl |=> data_ready_n [*8])
        else $error("Data-ready fell too soon after a mode change.");
    sync_halt_a: assert property (@(posedge mclk) disable iff (!reset_n)
        running && syncFall |=> state_q == amc_pkg::CtlSyncHold &&
        convCnt_q == '0 ##1 filterReset)
        else $error("Sync did not halt conversion and reset the filter.");
    pd_entry_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(powerDown) |-> $past(pdCnt_q) == PD_LIMIT && !$past(syncLvl))
        else $error("Power-down entered at the wrong hold time.");
    sync_ready_a: assert property (@(posedge mclk) disable iff (!reset_n)
        running && syncFall |=> data_ready_n ##1 data_ready_n)
        else $error("Data-ready not high at once on sync.");
    pd_cal_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(powerDown) |-> inputsShorted && convCnt_q == '0)
        else $error("Self-calibration did not follow power-down exit.");
    ready_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(readyLvl_q) |-> $past(state_q) == amc_pkg::CtlSettle &&
        $past(convDone))
        else $error("Ready raised without a settled filter.");
    frame_low_a: assert property (@(posedge sclk) disable iff (!reset_n)
        fmtSclk_q && !readySclk_q |=> !serialOut_q)
        else $error("Frame data output not low while settling.");

    cover_mode_change_c: cover property (@(posedge mclk)
        disable iff (!reset_n) modeApply);
    cover_sync_c: cover property (@(posedge mclk)
        disable iff (!reset_n) syncFall && running);
    cover_power_down_c: cover property (@(posedge mclk)
        disable iff (!reset_n) $fell(powerDown));
    cover_ready_c: cover property (@(posedge mclk)
        disable iff (!reset_n) $rose(readyLvl_q) && fmtLvl);

endmodule // amc_control

// ==== tb/amc_host_model.sv ====
/*
 * Controller-side model: shift clock, frame sync and the serial bit stream.
 * Assumes the bench picks the frame ratio; the shift clock is 64 ns.
 */
`timescale 1ns/1ps

module amc_host_model (
    input wire logic ratio512,
    output logic sclk,
    output logic frame_sync_in,
    output logic serialBitIn
);
    int bitCnt = 0;

    // The shift clock runs free, also during syncs, with its own phase.
    initial
    begin
        sclk = 1'b0;
        frame_sync_in = 1'b0;
        serialBitIn = 1'b0;
        #13;
        forever #32 sclk = ~sclk;
    end

    // A frame is 100 or 200 shift clocks, 256 or 512 master clock periods.
    always @(posedge sclk)
    begin
        bitCnt <= (bitCnt >= (ratio512 ? 199 : 99)) ? 0 : bitCnt + 1;
    end

    // Outputs move on the falling edge; the data bit toggles every cycle.
    always @(negedge sclk)
    begin
        frame_sync_in <= (bitCnt < 50);
        serialBitIn <= ~serialBitIn;
    end
endmodule // amc_host_model

// ==== tb/amc_control_bench.sv ====
/*
 * Self-checking bench for the mode, format and sync control block.
 * Assumes the host model drives the link and shortened debounce counts.
 */
`timescale 1ns/1ps

module amc_control_bench;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic modeDriven = 1'b1;
    logic modeLevel = 1'b0;
    logic formatSel = 1'b0;
    logic sync_powerdown_n = 1'b1;
    logic ratio512 = 1'b0;
    logic sclk, frame_sync_in, serialBitIn;
    logic [1:0] activeMode;
    logic frameFormat, frameRatio512, convStart, filterReset;
    logic offsetCalClear, offsetCalValid, powerDown, inputsShorted;
    logic data_ready_n, serialDataOut;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int convCnt = 0;
    int clrCnt = 0;
    int onesSeen = 0;
    int n, c0, base;
    logic [1:0] tabMode [3] = '{amc_pkg::MODE_LOW_POWER,
        amc_pkg::MODE_HIGH_RES, amc_pkg::MODE_HIGH_SPEED};
    logic tabDrv [3] = '{1'b1, 1'b0, 1'b1};
    logic tabLvl [3] = '{1'b1, 1'b0, 1'b0};
    int tabPer [3] = '{512, 512, 256};

    // Master clock at 40 MHz.
    always #12.5 mclk = ~mclk;

    amc_control #(
        .MODE_DEBOUNCE_CYCLES(16),
        .POWERDOWN_HOLD_CYCLES(64)
    ) dut (
        .mclk(mclk), .reset_n(reset_n), .modeDriven(modeDriven),
        .modeLevel(modeLevel), .formatSel(formatSel),
        .sync_powerdown_n(sync_powerdown_n),
        .frame_sync_in(frame_sync_in), .sclk(sclk),
        .serialBitIn(serialBitIn), .activeMode(activeMode),
        .frameFormat(frameFormat), .frameRatio512(frameRatio512),
        .convStart(convStart), .filterReset(filterReset),
        .offsetCalClear(offsetCalClear), .offsetCalValid(offsetCalValid),
        .powerDown(powerDown), .inputsShorted(inputsShorted),
        .data_ready_n(data_ready_n), .serialDataOut(serialDataOut)
    );

    amc_host_model host (
        .ratio512(ratio512), .sclk(sclk),
        .frame_sync_in(frame_sync_in), .serialBitIn(serialBitIn)
    );

    // Event monitors count pulses and ones on the serial output.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (convStart === 1'b1) convCnt <= convCnt + 1;
        if (offsetCalClear === 1'b1) clrCnt <= clrCnt + 1;
        if (cyc == 90000)
        begin
            error_cnt++;
            $display("CHECK FAILED timeout expected 0 seen 1");
            tally_and_finish();
        end
    end
    always @(posedge sclk)
    begin
        if (serialDataOut === 1'b1) onesSeen <= onesSeen + 1;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_val(string nm, logic [1:0] e, logic [1:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic chk_cnt(string nm, int e, int g);
        samples_checked++;
        if (g != e)
        begin
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
            error_cnt++;
        end
    endtask

    // Steps past a rising edge and lets its updates land.
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    task automatic drv_sync(logic v);
        @(posedge mclk);
        sync_powerdown_n <= v;
    endtask

    function automatic logic pick(int w);
        case (w)
            0: pick = data_ready_n;
            1: pick = inputsShorted;
            default: pick = convStart;
        endcase
    endfunction

    // Waits, bounded, until the chosen output shows the given level.
    task automatic wait_sig(int w, logic v, int lim, output int cnt);
        cnt = 0;
        do
        begin
            tick();
            cnt++;
        end while (pick(w) !== v && cnt < lim);
    endtask

    task automatic period(output int p);
        wait_sig(2, 1'b1, 1100, p);
        wait_sig(2, 1'b1, 1100, p);
    endtask

    // Changes the mode pins and checks the delayed mode update.
    task automatic set_mode(logic drv, logic lvl, logic [1:0] e);
        int k;
        int c;
        c = clrCnt;
        @(posedge mclk);
        modeDriven <= drv;
        modeLevel <= lvl;
        k = 0;
        do
        begin
            tick();
            k++;
        end while (activeMode !== e && k < 60);
        chk_val("activeMode", e, activeMode);
        chk_cnt("mode delay ok", 1, int'(k >= 16 && k <= 30));
        tick();
        chk_cnt("cal clear pulses", 1, clrCnt - c);
        chk_val("offsetCalValid", 1'b0, offsetCalValid);
    endtask

    // Main sequence of tests.
    initial
    begin
        repeat (3) @(posedge mclk);
        #1;
        chk_val("reset mode", amc_pkg::ACTIVE_MODE_RESET, activeMode);
        chk_val("reset ready", 1'b1, data_ready_n);
        chk_val("reset ratio", 1'b1, frameRatio512);
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        wait_sig(0, 1'b0, 21000, n);
        chk_cnt("startup settle", 76, (n + 128) / 256);
        period(n);
        chk_cnt("hs period", 256, n);
        $display("test startup done");

        drv_sync(1'b0);
        repeat (6) tick();
        c0 = convCnt;
        chk_val("sync ready", 1'b1, data_ready_n);
        chk_val("sync filter", 1'b1, filterReset);
        repeat (4) tick();
        chk_cnt("halted conv", c0, convCnt);
        drv_sync(1'b1);
        repeat (6) tick();
        chk_val("run filter", 1'b0, filterReset);
        chk_val("settle ready", 1'b1, data_ready_n);
        $display("test sync done");

        drv_sync(1'b0);
        repeat (50) tick();
        chk_val("short low", 1'b0, powerDown);
        repeat (50) tick();
        chk_val("long low", 1'b1, powerDown);
        drv_sync(1'b1);
        repeat (6) tick();
        chk_val("pd exit", 1'b0, powerDown);
        chk_val("shorted", 1'b1, inputsShorted);
        chk_val("pd ready", 1'b1, data_ready_n);
        wait_sig(1, 1'b0, 4800, n);
        chk_cnt("cal conv", 16, (n + 128) / 256);
        chk_val("cal valid", 1'b1, offsetCalValid);
        chk_val("cal ready", 1'b1, data_ready_n);
        wait_sig(0, 1'b0, 21000, n);
        chk_cnt("pd settle", 76, (n + 128) / 256);
        $display("test powerdown done");

        for (int i = 0; i < 3; i++)
        begin
            set_mode(tabDrv[i], tabLvl[i], tabMode[i]);
            period(n);
            chk_cnt("spi period", tabPer[i], n);
            chk_val("mode ready", 1'b1, data_ready_n);
        end
        c0 = clrCnt;
        @(posedge mclk);
        modeDriven <= 1'b0;
        repeat (8) @(posedge mclk);
        modeDriven <= 1'b1;
        repeat (40) tick();
        chk_val("glitch mode", amc_pkg::MODE_HIGH_SPEED, activeMode);
        chk_cnt("glitch clear", c0, clrCnt);
        $display("test modes done");

        set_mode(1'b1, 1'b1, amc_pkg::MODE_LOW_POWER);
        @(posedge mclk);
        formatSel <= 1'b1;
        repeat (4) tick();
        drv_sync(1'b0);
        repeat (10) tick();
        drv_sync(1'b1);
        repeat (4) tick();
        base = onesSeen;
        chk_val("frame format", 1'b1, frameFormat);
        chk_val("frame ready", 1'b1, data_ready_n);
        period(n);
        chk_cnt("lp 256 period", 256, n);
        chk_val("ratio 256", 1'b0, frameRatio512);
        repeat (17000) tick();
        chk_cnt("gated ones", 0, onesSeen - base);
        n = 0;
        while (onesSeen == base && n < 3500)
        begin
            tick();
            n++;
        end
        chk_cnt("data released", 1, int'(onesSeen > base));
        @(posedge mclk);
        ratio512 <= 1'b1;
        repeat (1200) tick();
        chk_val("ratio 512", 1'b1, frameRatio512);
        period(n);
        chk_cnt("lp 512 period", 512, n);
        set_mode(1'b1, 1'b0, amc_pkg::MODE_HIGH_SPEED);
        repeat (8) tick();
        base = onesSeen;
        period(n);
        chk_cnt("hs frame period", 256, n);
        chk_cnt("mode gated ones", 0, onesSeen - base);
        $display("test frame done");

        // The controller recalibrates on power-down exit after the mode change.
        drv_sync(1'b0);
        repeat (100) tick();
        chk_val("recal pd", 1'b1, powerDown);
        drv_sync(1'b1);
        repeat (6) tick();
        chk_val("recal clear", 1'b0, offsetCalValid);
        wait_sig(1, 1'b0, 4800, n);
        chk_cnt("recal conv", 16, (n + 128) / 256);
        chk_val("recal valid", 1'b1, offsetCalValid);
        $display("test recal done");
        tally_and_finish();
    end
endmodule // amc_control_bench
